// [design/rbs_exec_map.vh]
// Constants for the relative branch and bit-set execution block
// Functional notes
// - A word whose top four bits are 1101 is an unconditional relative branch with an 11-bit signed offset from -1024 to 1023.
// - The branch target is the incremented program counter plus twice the signed offset.
// - The branch takes two instruction cycles, writes the program counter in the last phase of the first, idles in the second and touches no status flag.
// - A word 1000 bbba ffff ffff sets bit b of register f in one cycle: read in phase two, set in phase three, write in phase four, no flag change.
// - With the a bit zero the bit-set uses the access bank, with it one the bank select register picks the bank.
// - With the extended set on and a zero, a bit-set operand of at most 95 uses indexed literal offset addressing.
`ifndef RBS_EXEC_MAP_VH
`define RBS_EXEC_MAP_VH
`define OPC_BRANCH      4'hD
`define OPC_BITSET      4'h8
`define OPC_HI          15
`define OPC_LO          12
`define OFS_HI          10
`define BIT_HI          11
`define BIT_LO          9
`define ABIT_POS        8
`define ILO_LIMIT       8'h5F
`define ACC_SPLIT       8'h60
`define ACC_BANK_LO     4'h0
`define ACC_BANK_HI     4'hF
`define PC_RESET        21'h000000
`define IR_RESET        16'h0000
`define WORK_RESET      8'h00
`define ADDR_RESET      12'h000
`define FLD_HI          7
`define SET_ONE         8'h01
`define PHASE_Q1        4'h1
`define PHASE_Q2        4'h2
`define PHASE_Q3        4'h4
`define PHASE_Q4        4'h8
`endif

// [design/phase_gen.v]
// Four-phase instruction cycle generator
`timescale 1ns/100ps
module phase_gen (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // One-hot phase
  output reg  [3:0] phase
);
`include "rbs_exec_map.vh"
  // Rotate Q1..Q4
  always @(posedge ref_clk) begin
    if (rst) begin
      phase <= `PHASE_Q1;
    end else begin
      phase <= {phase[2:0], phase[3]};
    end
  end
endmodule // phase_gen

// [design/rbs_exec.v]
// Decode and execute of unconditional branch and bit-set instructions
`timescale 1ns/100ps
module rbs_exec (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Instruction and core state
  input  wire [15:0] instr,
  input  wire [20:0] pc_in,
  input  wire [3:0]  bank_select_register,
  input  wire        ext_set_en,
  input  wire [11:0] fsr2_base,
  // Data memory read path
  input  wire [7:0]  rd_data,
  // Program counter write
  output reg  [20:0] pc_out,
  output reg         pc_we,
  // Data memory access
  output reg  [11:0] dm_addr,
  output reg         dm_re,
  output reg  [7:0]  wr_data,
  output reg         dm_we,
  // Status and sequencing
  output reg         status_we,
  output reg         flush,
  output reg  [3:0]  phase_out
);
`include "rbs_exec_map.vh"
  localparam ST_EXEC = 2'b01;
  localparam ST_NOP  = 2'b10;

  wire [3:0]  phase;
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [15:0] ir;
  reg  [7:0]  work;
  wire        is_branch;
  wire        is_bitset;
  wire [20:0] ofs_ext;
  wire [7:0]  fld;
  wire        abit;
  wire [2:0]  bsel;
  reg  [11:0] next_addr;
  // Phase strobes and addressing mode
  wire        exec_cyc;
  wire        in_q1;
  wire        in_q2;
  wire        in_q3;
  wire        in_q4;
  wire        use_bank_reg;
  wire        use_indexed;
  wire        use_acc_hi;
  wire [11:0] ilo_addr;
  // Datapath results
  wire [7:0]  set_mask;
  wire [7:0]  next_work;
  wire [20:0] next_pc;
  genvar      gi;

  // Phase rotation shared by both instructions
  phase_gen u_phase (
    .ref_clk (ref_clk),
    .rst     (rst),
    .phase   (phase)
  );

  // Opcode decode of the latched word
  assign is_branch = ir[`OPC_HI:`OPC_LO] == `OPC_BRANCH;
  assign is_bitset = ir[`OPC_HI:`OPC_LO] == `OPC_BITSET;
  // Sign-extended word offset doubled
  assign ofs_ext = {{9{ir[`OFS_HI]}}, ir[`OFS_HI:0], 1'b0};
  // Operand fields of the bit-set word
  assign fld  = ir[`FLD_HI:0];
  assign abit = ir[`ABIT_POS];
  assign bsel = ir[`BIT_HI:`BIT_LO];

  // Phase strobes, live only in an executing cycle
  assign exec_cyc = (state == ST_EXEC);
  assign in_q1    = exec_cyc && (phase == `PHASE_Q1);
  assign in_q2    = exec_cyc && (phase == `PHASE_Q2);
  assign in_q3    = exec_cyc && (phase == `PHASE_Q3);
  assign in_q4    = exec_cyc && (phase == `PHASE_Q4);

  // Addressing mode of the bit-set operand
  assign use_bank_reg = abit;
  assign use_indexed  = !abit && ext_set_en && (fld <= `ILO_LIMIT);
  assign use_acc_hi   = (fld >= `ACC_SPLIT);
  // Indexed offset wraps inside the 12-bit data space, no carry out
  assign ilo_addr = fsr2_base + {4'h0, fld};

  // Bank and address selection for bit-set
  always @* begin
    if (use_bank_reg) begin
      next_addr = {bank_select_register, fld};
    end else if (use_indexed) begin
      next_addr = ilo_addr;
    end else if (use_acc_hi) begin
      next_addr = {`ACC_BANK_HI, fld};
    end else begin
      next_addr = {`ACC_BANK_LO, fld};
    end
  end

  // Per-bit set: the selected bit is forced high, the rest pass
  assign set_mask = `SET_ONE << bsel;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_set
      assign next_work[gi] = rd_data[gi] | set_mask[gi];
    end
  endgenerate

  // Branch target from the already incremented address
  assign next_pc = pc_in + ofs_ext;

  // Cycle state: second cycle of a branch is a no-op
  always @* begin
    case (state)
      ST_EXEC: begin
        if (phase == `PHASE_Q4 && is_branch) begin
          next_state = ST_NOP;
        end else begin
          next_state = ST_EXEC;
        end
      end
      ST_NOP: begin
        if (phase == `PHASE_Q4) begin
          next_state = ST_EXEC;
        end else begin
          next_state = ST_NOP;
        end
      end
      default: next_state = ST_EXEC;
    endcase
  end

  // Cycle state register
  always @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_EXEC;
    end else begin
      state <= next_state;
    end
  end

  // Phase seen outside, one clock behind the internal phase
  always @(posedge ref_clk) begin
    if (rst) begin
      phase_out <= `PHASE_Q1;
    end else begin
      phase_out <= phase;
    end
  end

  // Instruction latch in the decode phase; idle cycle ignores the word
  always @(posedge ref_clk) begin
    if (rst) begin
      ir <= `IR_RESET;
    end else if (in_q1) begin
      ir <= instr;
    end
  end

  // Read request and address of the bit-set operand
  always @(posedge ref_clk) begin
    if (rst) begin
      dm_addr <= `ADDR_RESET;
      dm_re   <= 1'b0;
    end else begin
      dm_re <= 1'b0;
      if (in_q2 && is_bitset) begin
        dm_addr <= next_addr;
        dm_re   <= 1'b1;
      end
    end
  end

  // Modified operand held from process to write phase
  always @(posedge ref_clk) begin
    if (rst) begin
      work <= `WORK_RESET;
    end else if (in_q3 && is_bitset) begin
      work <= next_work;
    end
  end

  // Write-back of the modified operand
  always @(posedge ref_clk) begin
    if (rst) begin
      wr_data <= `WORK_RESET;
      dm_we   <= 1'b0;
    end else begin
      dm_we <= 1'b0;
      if (in_q4 && is_bitset) begin
        wr_data <= work;
        dm_we   <= 1'b1;
      end
    end
  end

  // Program counter write and fetch flush of the branch
  always @(posedge ref_clk) begin
    if (rst) begin
      pc_out <= `PC_RESET;
      pc_we  <= 1'b0;
      flush  <= 1'b0;
    end else begin
      pc_we <= 1'b0;
      flush <= 1'b0;
      if (in_q4 && is_branch) begin
        pc_out <= next_pc;
        pc_we  <= 1'b1;
        flush  <= 1'b1;
      end
    end
  end

  // Status flags are never written by either instruction
  always @(posedge ref_clk) begin
    if (rst) begin
      status_we <= 1'b0;
    end else begin
      status_we <= 1'b0;
    end
  end
endmodule // rbs_exec

// [sim/rbs_exec_sva.sv]
// Assertions on the branch and bit-set block ports
`timescale 1ns/100ps
module rbs_exec_sva (
  // Clock, reset and strobes
  input wire logic        ref_clk, rst, ext_set_en, pc_we, flush,
  input wire logic        dm_re, dm_we, status_we,
  // Buses
  input wire logic [15:0] instr,
  input wire logic [20:0] pc_in, pc_out,
  input wire logic [3:0]  bank_select_register,
  input wire logic [11:0] fsr2_base, dm_addr,
  input wire logic [7:0]  rd_data, wr_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Expected data address of a bit-set
  function automatic [11:0] ea(input [15:0] i);
    if (i[8]) ea = {bank_select_register, i[7:0]};
    else if (ext_set_en && i[7:0] <= 8'h5F) ea = fsr2_base + i[7:0];
    else ea = {(i[7:0] < 8'h60) ? 4'h0 : 4'hF, i[7:0]};
  endfunction
  // Steps of a bit-set and of the branch idle cycle
  sequence s_rd; $rose(dm_re); endsequence
  sequence s_wr; ##2 dm_we ##1 !dm_we; endsequence
  sequence s_idle; (!pc_we && !dm_re)[*4]; endsequence
  a_flags_kept: assert property (status_we == 1'b0)
    else $error("status write seen");
  a_flush_pc: assert property (pc_we == flush)
    else $error("flush not paired with pc write");
  a_rd_wr: assert property (s_rd |-> s_wr)
    else $error("write not two clocks after read");
  a_rd_op: assert property (dm_re |-> $past(instr[15:12], 2) == 4'h8)
    else $error("read without bit-set opcode");
  a_bank_addr: assert property (dm_re |-> dm_addr == ea($past(instr, 2)))
    else $error("bit-set address wrong");
  a_set_bit: assert property (dm_we |-> wr_data ==
    ($past(rd_data, 2) | (8'h01 << $past(instr[11:9], 4))))
    else $error("written data wrong");
  a_br_op: assert property (pc_we |-> $past(instr[15:12], 4) == 4'hD)
    else $error("pc write without branch opcode");
  a_br_target: assert property (pc_we |-> pc_out == pc_in +
    {{9{$past(instr[10], 4)}}, $past(instr[10:0], 4), 1'b0})
    else $error("branch target wrong");
  a_br_idle: assert property (pc_we |=> s_idle)
    else $error("branch second cycle not idle");
endmodule // rbs_exec_sva

// [sim/tb_rbs_exec.sv]
// Testbench for the branch and bit-set block
`timescale 1ns/100ps
module tb_rbs_exec;
  logic        ref_clk = 0, rst = 1, ext_set_en = 0;
  logic [15:0] instr = 16'h0000, nxt = 16'h0000;
  logic [20:0] pc_in = 21'h001000, pc_out, pc_got, a_got, d_got, n_pc, n_wr;
  logic [3:0]  bank_select_register = 4'h5, phase_out;
  logic [11:0] fsr2_base = 12'h100, dm_addr;
  logic [7:0]  rd_data = 8'h0A, wr_data;
  logic        pc_we, dm_re, dm_we, status_we, flush;
  int          num_errors = 0, compares = 0;
  rbs_exec dut (.*);
  // Clock
  initial forever #20 ref_clk = ~ref_clk;
  // Verdict
  task automatic conclude;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [20:0] g, e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One instruction, watched over two instruction cycles, capturing writes
  task automatic run(input logic [15:0] i);
    int k;
    n_pc = 0; n_wr = 0; k = 0;
    do begin @(posedge ref_clk); #1 k++; end
    while (phase_out !== 4'h4 && k < 9);
    if (phase_out !== 4'h4) begin num_errors++; conclude; end
    @(posedge ref_clk) instr <= i;
    @(posedge ref_clk) instr <= 16'h0000;
    for (k = 1; k <= 8; k++) begin
      // Word offered in the next decode slot, refused after a branch
      @(posedge ref_clk) instr <= (k == 3) ? nxt : 16'h0000;
      #1;
      if (dm_we === 1'b1) begin
        n_wr++; a_got = {9'h000, dm_addr}; d_got = {13'h0, wr_data};
      end
      if (pc_we === 1'b1) begin n_pc++; pc_got = pc_out; end
    end
  endtask
  // Bit-set through the bank register
  task automatic t_bsr;
    run(16'h8F33);
    chk(a_got, 21'h533);
    chk(d_got, 21'h8A);
    chk(n_wr, 21'h1);
    $display("test bsr done");
  endtask
  // Access bank and indexed boundaries
  task automatic t_acc;
    run(16'h8060);
    chk(a_got, 21'hF60);
    run(16'h805F);
    chk(a_got, 21'h05F);
    @(posedge ref_clk) ext_set_en <= 1'b1;
    run(16'h845F);
    chk(a_got, 21'h15F);
    chk(d_got, 21'h0E);
    run(16'h8060);
    chk(a_got, 21'hF60);
    $display("test acc done");
  endtask
  // Branch offset extremes
  task automatic t_bra;
    run(16'hD400);
    chk(pc_got, 21'h000800);
    chk(n_wr, 21'h0);
    nxt = 16'h8F33;
    run(16'hD3FF);
    nxt = 16'h0000;
    chk(pc_got, 21'h0017FE);
    chk(n_pc, 21'h1);
    chk(n_wr, 21'h0);
    $display("test bra done");
  endtask
  // Foreign opcode does nothing
  task automatic t_oth;
    run(16'h9F33);
    chk(n_wr + n_pc, 21'h0);
    $display("test oth done");
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_bsr; t_acc; t_bra; t_oth;
    conclude;
  end
endmodule // tb_rbs_exec
bind rbs_exec rbs_exec_sva sva (
  .ref_clk (ref_clk), .rst (rst), .ext_set_en (ext_set_en), .pc_we (pc_we),
  .flush (flush), .dm_re (dm_re), .dm_we (dm_we), .status_we (status_we),
  .instr (instr), .pc_in (pc_in), .pc_out (pc_out),
  .bank_select_register (bank_select_register), .fsr2_base (fsr2_base),
  .dm_addr (dm_addr), .rd_data (rd_data), .wr_data (wr_data));
